// ===== codec_config_register_bank.sv
// Configuration register bank of the voice codec, written over the serial port
// Notes on behaviour
// - The host configures the codec by serial writes, and each write to a non-reserved register lands in it; reserved addresses keep their defaults.
// - Each register is 8 bits at its own address; the map covers 0x00 to 0x0F.
// - Every register loads its default at start-up so the codec runs unprogrammed.
// - The analog input register enables the microphone bias and sets preamplifier gain.
// - The block register holds DAC detector enable, DAC enable, ADC enable and clock division.
// - The audio port register sets loopback, receive slot, role, impedance, transmit and frame.
// - The detector off-time is 16 bits, low byte at 0x0B and high byte at 0x0C.
// - The detector on-time comes from 0x0D and defaults to 0x00.
// - The detector ADC reference comes from 0x0E and DAC reference from 0x0F, both 0x00.
// - Registers 0x0B to 0x0F serve only the detector and exist only with that option.
// - Clock division code 00 divides by 1, 01 by 2, 11 by 4, and 10 is reserved.
// - The preamplifier gain default follows the data-input pin level at start-up.
`timescale 1ns/1ns
module codec_config_register_bank #(
    parameter bit          DETECTOR_PRESENT = 1'b1,
    parameter logic [7:0]  AUDIO_PORT_RESET = codec_cfg_pkg::RST_AUDIO_PORT
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Serial register port pins
    input  wire logic        spi_ss_n,
    input  wire logic        spi_sck,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    // Analog control
    output logic [7:0]       adc_bias_current,
    output logic             mic_bias_en,
    output logic             preamp_gain_high,
    // Block enables and clock division
    output logic             dac_detect_en,
    output logic             dac_enable,
    output logic             adc_enable,
    output logic [1:0]       clk_divide_select,
    output logic [2:0]       clk_divide_factor,
    output logic             clk_divide_invalid,
    // Audio port setup
    output logic             loopback_en,
    output logic             rx_second_slot,
    output logic             audio_master,
    output logic             sdo_hiz_en,
    output logic             tx_first_slot,
    output logic             tx_second_slot,
    output logic             long_frame_format,
    output logic             short_frame_format,
    // Presence detector parameters
    output logic [15:0]      detect_off_time,
    output logic [7:0]       detect_on_time,
    output logic [7:0]       detect_adc_reference,
    output logic [7:0]       detect_dac_reference,
    // Start-up status
    output logic             config_ready
);

    // Synchronised pins
    logic       ss_n_s;
    logic       sck_s;
    logic       mosi_s;

    // Serial engine outputs and read data input
    logic [3:0] acc_addr;
    logic [7:0] acc_wdata;
    logic       acc_wr;
    logic [7:0] acc_rdata;

    typedef struct packed {
        logic       strap_pending;
        logic       ready;
        logic [7:0] adc_bias_current;
        logic [7:0] analog_input_setup;
        logic [7:0] block_enable_clkdiv;
        logic [7:0] audio_port_config;
        logic [7:0] detect_off_time_low;
        logic [7:0] detect_off_time_high;
        logic [7:0] detect_on_time;
        logic [7:0] detect_adc_reference;
        logic [7:0] detect_dac_reference;
    } bank_state_t;

    bank_state_t bank_q;
    bank_state_t bank_d;

    logic [1:0]  div_code;

    pin_sync #(
        .WIDTH   (3),
        .RST_VAL (3'b101)
    ) u_pin_sync (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .pin_in       ({spi_ss_n, spi_sck, spi_mosi}),
        .pin_sync_out ({ss_n_s, sck_s, mosi_s})
    );

    spi_frame u_spi_frame (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .ss_n_s   (ss_n_s),
        .sck_s    (sck_s),
        .mosi_s   (mosi_s),
        .rd_data  (acc_rdata),
        .reg_addr (acc_addr),
        .wr_data  (acc_wdata),
        .wr_pulse (acc_wr),
        .miso     (spi_miso),
        .miso_oe  (spi_miso_oe)
    );

    // Read-back of the full map
    always_comb begin
        if (acc_addr == codec_cfg_pkg::OFS_RSVD_00) begin
            acc_rdata = codec_cfg_pkg::RST_RSVD_00;
        end else if (acc_addr == codec_cfg_pkg::OFS_RSVD_01) begin
            acc_rdata = codec_cfg_pkg::RST_RSVD_01;
        end else if (acc_addr == codec_cfg_pkg::OFS_ADC_CURRENT) begin
            acc_rdata = bank_q.adc_bias_current;
        end else if (acc_addr == codec_cfg_pkg::OFS_RSVD_03) begin
            acc_rdata = codec_cfg_pkg::RST_RSVD_03;
        end else if (acc_addr == codec_cfg_pkg::OFS_ANALOG_INPUT) begin
            acc_rdata = bank_q.analog_input_setup;
        end else if (acc_addr == codec_cfg_pkg::OFS_RSVD_05) begin
            acc_rdata = codec_cfg_pkg::RST_RSVD_05;
        end else if (acc_addr == codec_cfg_pkg::OFS_RSVD_06) begin
            acc_rdata = codec_cfg_pkg::RST_RSVD_06;
        end else if (acc_addr == codec_cfg_pkg::OFS_RSVD_07) begin
            acc_rdata = codec_cfg_pkg::RST_RSVD_07;
        end else if (acc_addr == codec_cfg_pkg::OFS_BLOCK_ENABLE) begin
            acc_rdata = bank_q.block_enable_clkdiv;
        end else if (acc_addr == codec_cfg_pkg::OFS_AUDIO_PORT) begin
            acc_rdata = bank_q.audio_port_config;
        end else if (acc_addr == codec_cfg_pkg::OFS_RSVD_0A) begin
            acc_rdata = codec_cfg_pkg::RST_RSVD_0A;
        end else if (!DETECTOR_PRESENT) begin
            acc_rdata = 8'h00;
        end else if (acc_addr == codec_cfg_pkg::OFS_OFF_TIME_LOW) begin
            acc_rdata = bank_q.detect_off_time_low;
        end else if (acc_addr == codec_cfg_pkg::OFS_OFF_TIME_HIGH) begin
            acc_rdata = bank_q.detect_off_time_high;
        end else if (acc_addr == codec_cfg_pkg::OFS_ON_TIME) begin
            acc_rdata = bank_q.detect_on_time;
        end else if (acc_addr == codec_cfg_pkg::OFS_ADC_REFERENCE) begin
            acc_rdata = bank_q.detect_adc_reference;
        end else begin
            acc_rdata = bank_q.detect_dac_reference;
        end
    end

    // Register update
    always_comb begin
        bank_d = bank_q;
        // Strap capture on the first cycle after reset release
        if (bank_q.strap_pending) begin
            bank_d.strap_pending = 1'b0;
            bank_d.ready         = 1'b1;
            bank_d.analog_input_setup[codec_cfg_pkg::BIT_PREAMP_GAIN] = mosi_s;
            bank_d.block_enable_clkdiv[codec_cfg_pkg::BIT_CLKDIV_LO]  = ~ss_n_s;
        end
        if (acc_wr && bank_q.ready) begin
            // Reserved addresses fall through and keep their defaults
            if (acc_addr == codec_cfg_pkg::OFS_ADC_CURRENT) begin
                bank_d.adc_bias_current = acc_wdata;
            end else if (acc_addr == codec_cfg_pkg::OFS_ANALOG_INPUT) begin
                bank_d.analog_input_setup = acc_wdata;
            end else if (acc_addr == codec_cfg_pkg::OFS_BLOCK_ENABLE) begin
                bank_d.block_enable_clkdiv = acc_wdata;
            end else if (acc_addr == codec_cfg_pkg::OFS_AUDIO_PORT) begin
                bank_d.audio_port_config = acc_wdata;
            end else if (!DETECTOR_PRESENT) begin
                bank_d = bank_d;
            end else if (acc_addr == codec_cfg_pkg::OFS_OFF_TIME_LOW) begin
                bank_d.detect_off_time_low = acc_wdata;
            end else if (acc_addr == codec_cfg_pkg::OFS_OFF_TIME_HIGH) begin
                bank_d.detect_off_time_high = acc_wdata;
            end else if (acc_addr == codec_cfg_pkg::OFS_ON_TIME) begin
                bank_d.detect_on_time = acc_wdata;
            end else if (acc_addr == codec_cfg_pkg::OFS_ADC_REFERENCE) begin
                bank_d.detect_adc_reference = acc_wdata;
            end else if (acc_addr == codec_cfg_pkg::OFS_DAC_REFERENCE) begin
                bank_d.detect_dac_reference = acc_wdata;
            end else begin
                bank_d = bank_d;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // Defaults; strap bits merge one cycle after release
            bank_q.strap_pending        <= 1'b1;
            bank_q.ready                <= 1'b0;
            bank_q.adc_bias_current     <= codec_cfg_pkg::RST_ADC_CURRENT;
            bank_q.analog_input_setup   <= codec_cfg_pkg::RST_ANALOG_INPUT;
            bank_q.block_enable_clkdiv  <= codec_cfg_pkg::RST_BLOCK_ENABLE;
            bank_q.audio_port_config    <= AUDIO_PORT_RESET;
            bank_q.detect_off_time_low  <= codec_cfg_pkg::RST_DETECT;
            bank_q.detect_off_time_high <= codec_cfg_pkg::RST_DETECT;
            bank_q.detect_on_time       <= codec_cfg_pkg::RST_DETECT;
            bank_q.detect_adc_reference <= codec_cfg_pkg::RST_DETECT;
            bank_q.detect_dac_reference <= codec_cfg_pkg::RST_DETECT;
        end else begin
            bank_q <= bank_d;
        end
    end

    // Analog controls
    assign adc_bias_current = bank_q.adc_bias_current;
    assign mic_bias_en      = bank_q.analog_input_setup[codec_cfg_pkg::BIT_MIC_BIAS_EN];
    assign preamp_gain_high = bank_q.analog_input_setup[codec_cfg_pkg::BIT_PREAMP_GAIN];

    // Block enables; the DAC and ADC bits are active-low enables, the DAC detector bit is active-high
    assign dac_detect_en = DETECTOR_PRESENT &
                           bank_q.block_enable_clkdiv[codec_cfg_pkg::BIT_DAC_DETECT_EN];
    assign dac_enable    = ~bank_q.block_enable_clkdiv[codec_cfg_pkg::BIT_DAC_DISABLE];
    assign adc_enable    = ~bank_q.block_enable_clkdiv[codec_cfg_pkg::BIT_ADC_DISABLE];
    assign div_code      = bank_q.block_enable_clkdiv[codec_cfg_pkg::BIT_CLKDIV_HI:
                                                      codec_cfg_pkg::BIT_CLKDIV_LO];
    assign clk_divide_select = div_code;

    // Division factor decode; reserved code holds divide by 1
    always_comb begin
        clk_divide_invalid = 1'b0;
        case (div_code)
            codec_cfg_pkg::CLKDIV_BY1: clk_divide_factor = codec_cfg_pkg::DIV_FACTOR_1;
            codec_cfg_pkg::CLKDIV_BY2: clk_divide_factor = codec_cfg_pkg::DIV_FACTOR_2;
            codec_cfg_pkg::CLKDIV_BY4: clk_divide_factor = codec_cfg_pkg::DIV_FACTOR_4;
            default: begin
                clk_divide_factor  = codec_cfg_pkg::DIV_FACTOR_1;
                clk_divide_invalid = 1'b1;
            end
        endcase
    end

    // Audio port setup
    assign loopback_en        = bank_q.audio_port_config[codec_cfg_pkg::BIT_LOOPBACK];
    assign rx_second_slot     = bank_q.audio_port_config[codec_cfg_pkg::BIT_RX_SECOND];
    assign audio_master       = bank_q.audio_port_config[codec_cfg_pkg::BIT_MASTER];
    assign sdo_hiz_en         = bank_q.audio_port_config[codec_cfg_pkg::BIT_SDO_HIZ_EN];
    assign tx_first_slot      = bank_q.audio_port_config[codec_cfg_pkg::BIT_TX_FIRST];
    assign tx_second_slot     = bank_q.audio_port_config[codec_cfg_pkg::BIT_TX_SECOND];
    assign long_frame_format  = bank_q.audio_port_config[codec_cfg_pkg::BIT_LONG_FRAME];
    assign short_frame_format = ~bank_q.audio_port_config[codec_cfg_pkg::BIT_LONG_FRAME];

    // Detector parameters
    assign detect_off_time      = {bank_q.detect_off_time_high,
                                   bank_q.detect_off_time_low};
    assign detect_on_time       = bank_q.detect_on_time;
    assign detect_adc_reference = bank_q.detect_adc_reference;
    assign detect_dac_reference = bank_q.detect_dac_reference;

    assign config_ready = bank_q.ready;

endmodule

// ===== codec_cfg_pkg.sv
// Shared constants of the codec configuration register bank
package codec_cfg_pkg;

    // Register geometry
    localparam int unsigned REG_WIDTH  = 8;
    localparam int unsigned ADDR_WIDTH = 4;
    localparam int unsigned REG_COUNT  = 16;
    localparam int unsigned DOC_REG_COUNT = 24;

    // Register offsets
    localparam logic [3:0] OFS_RSVD_00        = 4'h0;
    localparam logic [3:0] OFS_RSVD_01        = 4'h1;
    localparam logic [3:0] OFS_ADC_CURRENT    = 4'h2;
    localparam logic [3:0] OFS_RSVD_03        = 4'h3;
    localparam logic [3:0] OFS_ANALOG_INPUT   = 4'h4;
    localparam logic [3:0] OFS_RSVD_05        = 4'h5;
    localparam logic [3:0] OFS_RSVD_06        = 4'h6;
    localparam logic [3:0] OFS_RSVD_07        = 4'h7;
    localparam logic [3:0] OFS_BLOCK_ENABLE   = 4'h8;
    localparam logic [3:0] OFS_AUDIO_PORT     = 4'h9;
    localparam logic [3:0] OFS_RSVD_0A        = 4'hA;
    localparam logic [3:0] OFS_OFF_TIME_LOW   = 4'hB;
    localparam logic [3:0] OFS_OFF_TIME_HIGH  = 4'hC;
    localparam logic [3:0] OFS_ON_TIME        = 4'hD;
    localparam logic [3:0] OFS_ADC_REFERENCE  = 4'hE;
    localparam logic [3:0] OFS_DAC_REFERENCE  = 4'hF;

    // Reset values (strap bits cleared; they are merged at start-up)
    localparam logic [7:0] RST_RSVD_00       = 8'h48;
    localparam logic [7:0] RST_RSVD_01       = 8'h8F;
    localparam logic [7:0] RST_ADC_CURRENT   = 8'hF0;
    localparam logic [7:0] RST_RSVD_03       = 8'h00;
    localparam logic [7:0] RST_ANALOG_INPUT  = 8'h08;
    localparam logic [7:0] RST_RSVD_05       = 8'h82;
    localparam logic [7:0] RST_RSVD_06       = 8'h00;
    localparam logic [7:0] RST_RSVD_07       = 8'h00;
    localparam logic [7:0] RST_BLOCK_ENABLE  = 8'h00;
    localparam logic [7:0] RST_AUDIO_PORT    = 8'h25;
    localparam logic [7:0] RST_RSVD_0A       = 8'h00;
    localparam logic [7:0] RST_DETECT        = 8'h00;

    // Recommended ADC current codes
    localparam logic [7:0] ADC_CURRENT_LOW_RATE  = 8'hF0;
    localparam logic [7:0] ADC_CURRENT_HIGH_RATE = 8'hC4;

    // Analog input fields
    localparam int unsigned BIT_MIC_BIAS_EN  = 7;
    localparam int unsigned BIT_PREAMP_GAIN  = 2;

    // Block enable fields
    localparam int unsigned BIT_DAC_DETECT_EN = 4;
    localparam int unsigned BIT_DAC_DISABLE   = 3;
    localparam int unsigned BIT_ADC_DISABLE   = 2;
    localparam int unsigned BIT_CLKDIV_HI     = 1;
    localparam int unsigned BIT_CLKDIV_LO     = 0;

    // Clock division codes
    localparam logic [1:0] CLKDIV_BY1  = 2'b00;
    localparam logic [1:0] CLKDIV_BY2  = 2'b01;
    localparam logic [1:0] CLKDIV_RSVD = 2'b10;
    localparam logic [1:0] CLKDIV_BY4  = 2'b11;
    localparam logic [2:0] DIV_FACTOR_1 = 3'h1;
    localparam logic [2:0] DIV_FACTOR_2 = 3'h2;
    localparam logic [2:0] DIV_FACTOR_4 = 3'h4;

    // Audio port fields
    localparam int unsigned BIT_LOOPBACK     = 7;
    localparam int unsigned BIT_RX_SECOND    = 6;
    localparam int unsigned BIT_MASTER       = 4;
    localparam int unsigned BIT_SDO_HIZ_EN   = 3;
    localparam int unsigned BIT_TX_FIRST     = 2;
    localparam int unsigned BIT_TX_SECOND    = 1;
    localparam int unsigned BIT_LONG_FRAME   = 0;

    // Serial frame layout
    localparam int unsigned SPI_BITS    = 8;
    localparam int unsigned SPI_RW_BIT  = 7;
    localparam logic [2:0]  SPI_LAST_BIT = 3'h7;

endpackage

// ===== pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned WIDTH     = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state_q;
    sync_state_t state_d;

    always_comb begin
        state_d        = state_q;
        state_d.meta   = pin_in;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            // Keep sampling during reset so start-up straps see real pin levels
            state_q <= '{meta: pin_in, stable: state_q.meta};
        end else begin
            state_q <= state_d;
        end
    end

    assign pin_sync_out = state_q.stable;

endmodule

// ===== spi_frame.sv
// Serial port frame engine: address byte then one data byte
`timescale 1ns/1ns
module spi_frame (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       ss_n_s,
    input  wire logic       sck_s,
    input  wire logic       mosi_s,
    input  wire logic [7:0] rd_data,
    output logic [3:0]      reg_addr,
    output logic [7:0]      wr_data,
    output logic            wr_pulse,
    output logic            miso,
    output logic            miso_oe
);

    typedef struct packed {
        logic       sck_prev;
        logic [2:0] bit_cnt;
        logic       phase_data;
        logic       done;
        logic       is_read;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic [3:0] addr;
        logic [7:0] data;
        logic       wr;
        logic       miso;
        logic       oe;
    } frame_state_t;

    frame_state_t s_q;
    frame_state_t s_d;
    logic         rise;
    logic         fall;

    assign rise = sck_s & ~s_q.sck_prev;
    assign fall = ~sck_s & s_q.sck_prev;

    always_comb begin
        s_d          = s_q;
        s_d.sck_prev = sck_s;
        s_d.wr       = 1'b0;
        if (ss_n_s) begin
            s_d.bit_cnt    = '0;
            s_d.phase_data = 1'b0;
            s_d.done       = 1'b0;
            s_d.is_read    = 1'b0;
            s_d.oe         = 1'b0;
            s_d.miso       = 1'b0;
        end else if (rise && !s_q.done) begin
            s_d.shift_in = {s_q.shift_in[6:0], mosi_s};
            s_d.bit_cnt  = s_q.bit_cnt + 3'h1;
            if (s_q.bit_cnt == codec_cfg_pkg::SPI_LAST_BIT) begin
                if (!s_q.phase_data) begin
                    s_d.phase_data = 1'b1;
                    s_d.is_read    = s_d.shift_in[codec_cfg_pkg::SPI_RW_BIT];
                    s_d.addr       = s_d.shift_in[3:0];
                end else begin
                    s_d.done = 1'b1;
                    s_d.data = s_d.shift_in;
                    s_d.wr   = ~s_q.is_read;
                end
            end
        end else if (fall && s_q.phase_data && s_q.is_read && !s_q.done) begin
            // Read data shifts out MSB first on falling edges
            if (s_q.bit_cnt == 3'h0 && !s_q.oe) begin
                s_d.shift_out = {rd_data[6:0], 1'b0};
                s_d.miso      = rd_data[7];
                s_d.oe        = 1'b1;
            end else begin
                s_d.miso      = s_q.shift_out[7];
                s_d.shift_out = {s_q.shift_out[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_addr = s_q.addr;
    assign wr_data  = s_q.data;
    assign wr_pulse = s_q.wr;
    assign miso     = s_q.miso;
    assign miso_oe  = s_q.oe;

endmodule

// ===== spi_host.sv
// Serial host model that frames single register reads and writes
`timescale 1ns/1ns
module spi_host #(
    parameter int HALF = 8
) (
    input  wire logic sys_clk,
    input  wire logic miso,
    output logic      ss_n,
    output logic      sck,
    output logic      mosi
);
    initial begin
        ss_n = 1'b1;
        sck  = 1'b0;
        mosi = 1'b1;
    end
    // Pin levels outside frames, also the start-up straps
    task automatic idle(input logic sel_n, input logic dat);
        @(posedge sys_clk);
        ss_n <= sel_n;
        mosi <= dat;
    endtask
    // Command byte then data byte, MSB first, data sampled before each rise
    task automatic xfer(input logic rd, input logic [3:0] addr, input logic [7:0] wdat,
                        output logic [7:0] rdat);
        logic [15:0] frame;
        frame = {rd, 3'b000, addr, wdat};
        rdat  = 8'h00;
        @(posedge sys_clk);
        ss_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi <= frame[i];
            repeat (HALF) @(posedge sys_clk);
            if (i < 8) rdat[i] = miso;
            sck <= 1'b1;
            repeat (HALF) @(posedge sys_clk);
            sck <= 1'b0;
        end
        repeat (HALF) @(posedge sys_clk);
        ss_n <= 1'b1;
        repeat (HALF) @(posedge sys_clk);
    endtask
endmodule

// ===== bank_props.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
module bank_props (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        spi_ss_n,
    input wire logic        spi_miso_oe,
    input wire logic [7:0]  adc_bias_current,
    input wire logic [1:0]  clk_divide_select,
    input wire logic [2:0]  clk_divide_factor,
    input wire logic        clk_divide_invalid,
    input wire logic        long_frame_format,
    input wire logic        short_frame_format,
    input wire logic [15:0] detect_off_time,
    input wire logic        config_ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_SHORT_INV: assert property (short_frame_format == !long_frame_format)
        else $error("frame format outputs not complementary");
    AST_DIV_FACTOR: assert property (clk_divide_factor ==
        (clk_divide_select == codec_cfg_pkg::CLKDIV_BY4 ? codec_cfg_pkg::DIV_FACTOR_4 :
         clk_divide_select == codec_cfg_pkg::CLKDIV_BY2 ? codec_cfg_pkg::DIV_FACTOR_2 :
         codec_cfg_pkg::DIV_FACTOR_1))
        else $error("clock divide factor wrong");
    AST_DIV_INVALID: assert property (clk_divide_invalid == (clk_divide_select == 2'b10))
        else $error("reserved divide flag wrong");
    AST_OFF_WRITE: assert property ($changed(detect_off_time) |-> !$past(spi_ss_n, 3))
        else $error("off time changed outside a frame");
    AST_ADC_WRITE: assert property ($changed(adc_bias_current) |-> !$past(spi_ss_n, 3))
        else $error("adc current changed outside a frame");
    AST_OE_FRAME: assert property (spi_miso_oe |-> !$past(spi_ss_n, 5))
        else $error("miso driven outside a frame");
    AST_READY_UP: assert property ($fell(reset) |-> ##[0:2] config_ready)
        else $error("config ready late after reset");
    AST_READY_HOLD: assert property (config_ready |=> config_ready)
        else $error("config ready dropped");
    cover property ($changed(detect_off_time));
    cover property (spi_miso_oe);
    cover property (clk_divide_invalid);
endmodule
bind codec_config_register_bank bank_props i_props (
    .sys_clk(sys_clk), .reset(reset), .spi_ss_n(spi_ss_n), .spi_miso_oe(spi_miso_oe),
    .adc_bias_current(adc_bias_current), .clk_divide_select(clk_divide_select),
    .clk_divide_factor(clk_divide_factor), .clk_divide_invalid(clk_divide_invalid),
    .long_frame_format(long_frame_format), .short_frame_format(short_frame_format),
    .detect_off_time(detect_off_time), .config_ready(config_ready));

// ===== tb.sv
// Register bank testbench: serial reads and writes against expected values
`timescale 1ns/1ns
module tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic spi_ss_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe, mic_bias_en, preamp_gain_high;
    logic dac_detect_en, dac_enable, adc_enable, clk_divide_invalid, loopback_en;
    logic rx_second_slot, audio_master, sdo_hiz_en, tx_first_slot, tx_second_slot;
    logic long_frame_format, short_frame_format, config_ready;
    logic [7:0]  adc_bias_current, detect_on_time, detect_adc_reference, detect_dac_reference;
    logic [1:0]  clk_divide_select;
    logic [2:0]  clk_divide_factor;
    logic [15:0] detect_off_time;
    logic [7:0]  rd;
    logic [7:0]  dflt [16] = '{8'h48, 8'h8F, 8'hF0, 8'h00, 8'h0C, 8'h82, 8'h00, 8'h00,
                               8'h00, 8'h25, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  wv [16] = '{8'hA5, 8'hA5, 8'hC4, 8'hA5, 8'h88, 8'hA5, 8'hA5, 8'hA5,
                             8'h1F, 8'hFB, 8'hA5, 8'h34, 8'h12, 8'h56, 8'h9A, 8'hBC};
    logic [15:0] wmask = 16'hFB14;
    logic [2:0]  fac [4] = '{3'h1, 3'h2, 3'h1, 3'h4};
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    always #4 sys_clk = ~sys_clk;

    spi_host i_host (.sys_clk(sys_clk), .miso(spi_miso), .ss_n(spi_ss_n), .sck(spi_sck),
                     .mosi(spi_mosi));
    codec_config_register_bank i_dut (
        .sys_clk(sys_clk), .reset(reset), .spi_ss_n(spi_ss_n), .spi_sck(spi_sck),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
        .adc_bias_current(adc_bias_current), .mic_bias_en(mic_bias_en),
        .preamp_gain_high(preamp_gain_high), .dac_detect_en(dac_detect_en),
        .dac_enable(dac_enable), .adc_enable(adc_enable),
        .clk_divide_select(clk_divide_select), .clk_divide_factor(clk_divide_factor),
        .clk_divide_invalid(clk_divide_invalid), .loopback_en(loopback_en),
        .rx_second_slot(rx_second_slot), .audio_master(audio_master),
        .sdo_hiz_en(sdo_hiz_en), .tx_first_slot(tx_first_slot),
        .tx_second_slot(tx_second_slot), .long_frame_format(long_frame_format),
        .short_frame_format(short_frame_format), .detect_off_time(detect_off_time),
        .detect_on_time(detect_on_time), .detect_adc_reference(detect_adc_reference),
        .detect_dac_reference(detect_dac_reference), .config_ready(config_ready));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int a = 0; a < 16; a++) begin
            i_host.xfer(1'b1, 4'(a), 8'h00, rd);
            check(rd, dflt[a]);
        end
        for (int a = 0; a < 16; a++) i_host.xfer(1'b0, 4'(a), wv[a], rd);
        for (int a = 0; a < 16; a++) begin
            i_host.xfer(1'b1, 4'(a), 8'h00, rd);
            check(rd, wmask[a] ? wv[a] : dflt[a]);
        end
        check(adc_bias_current, 8'hC4);
        check({mic_bias_en, preamp_gain_high}, 2'b10);
        check({dac_detect_en, dac_enable, adc_enable}, 3'b100);
        check({loopback_en, rx_second_slot, audio_master, sdo_hiz_en, tx_first_slot,
               tx_second_slot, long_frame_format, short_frame_format}, 8'hF6);
        check(detect_off_time, 16'h1234);
        check(detect_on_time, 8'h56);
        check({detect_adc_reference, detect_dac_reference}, 16'h9ABC);
        for (int c = 0; c < 4; c++) begin
            i_host.xfer(1'b0, 4'h8, 8'(c), rd);
            check({clk_divide_select, clk_divide_factor, clk_divide_invalid},
                  {2'(c), fac[c], c == 2});
        end
        i_host.xfer(1'b0, 4'h2, 8'hF0, rd);
        check(adc_bias_current, 8'hF0);
        i_host.idle(1'b0, 1'b0);
        reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        i_host.idle(1'b1, 1'b1);
        repeat (6) @(posedge sys_clk);
        check({preamp_gain_high, clk_divide_select, clk_divide_factor}, 6'b0_01_010);
        check(detect_off_time, 16'h0000);
        i_host.xfer(1'b1, 4'h4, 8'h00, rd);
        check(rd, 8'h08);
        i_host.xfer(1'b1, 4'h8, 8'h00, rd);
        check(rd, 8'h01);
        wrap_up();
    end
endmodule
